// ==== rtl/sds_strap_decode.sv ====
// Power-up strap decoder with its converter sequencing and sink control.
// Function
// - Eight-bit successive-approximation result underlies all decoding.
// - Input multiplexer selects straps or other sources.
// - Every conversion result is held for firmware.
// - Convert both straps at power-up, then decide.
// - Strap decoding governs the dead-battery start-up.
// - Codes pick address, sink path, default configuration.
// - Codes 0 to 2 by low ratio bands.
// - Codes 3 to 5 by middle ratio bands.
// - Codes 6 and 7, top is regulator tie.
// - Sink pull-down presented during dead battery.
// - Control removes the dead-battery sink pull-down.
`timescale 1ns/10ps
module sds_strap_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Supply sense pins
    input wire logic system_supply_3v3,
    input wire logic port_a_bus_power,
    input wire logic port_b_bus_power,
    // Converter analog front end
    input wire logic adc_comp_above,
    output logic [sds_pkg::ADC_W-1:0] adc_trial_code,
    output logic [sds_pkg::MUX_W-1:0] adc_mux_sel,
    // Firmware conversion port
    input wire logic fw_conv_req,
    input wire logic [sds_pkg::MUX_W-1:0] fw_mux_sel,
    input wire logic fw_pulldown_release,
    output logic [sds_pkg::ADC_W-1:0] adc_result,
    output logic adc_result_valid,
    output logic fw_conv_busy,
    // Decoded strap values
    output logic [sds_pkg::CODE_W-1:0] strap_one_code,
    output logic [sds_pkg::CODE_W-1:0] strap_two_code,
    output logic straps_valid,
    // Start-up selections
    output logic dead_battery,
    output logic [sds_pkg::CODE_W-1:0] host_serial_port_addr_sel,
    output logic sink_path_enable,
    output logic [sds_pkg::CODE_W-1:0] default_config_sel,
    output logic sink_pulldown_enable
);
    sds_pkg::sds_state_type state_q, state_d;
    logic [sds_pkg::CNT_W-1:0] start_cnt_q, start_cnt_d;

    // Pin synchronisers: the first stage feeds only the second stage.
    logic [2:0] pins_meta_q, pins_sync_q;
    logic comp_meta_q, comp_sync_q;

    logic sar_start;
    logic [sds_pkg::ADC_W-1:0] sar_trial;
    logic sar_busy;
    logic sar_done;
    logic [sds_pkg::ADC_W-1:0] sar_result;

    logic [sds_pkg::MUX_W-1:0] mux_q, mux_d;
    logic [sds_pkg::ADC_W-1:0] trial_q;
    logic [sds_pkg::ADC_W-1:0] result_q, result_d;
    logic result_valid_q, result_valid_d;
    logic fw_busy_q;
    logic [sds_pkg::CODE_W-1:0] one_code_q, one_code_d;
    logic [sds_pkg::CODE_W-1:0] two_code_q, two_code_d;
    logic straps_valid_q, straps_valid_d;
    logic dead_q;
    logic [sds_pkg::CODE_W-1:0] addr_sel_q;
    logic sink_path_q;
    logic [sds_pkg::CODE_W-1:0] cfg_sel_q;
    logic pulldown_q, pulldown_d;

    logic bus_present;
    logic supply_present;
    logic dead_now;
    logic [sds_pkg::CODE_W-1:0] result_code;
    logic start_elapsed;

    // Converter sequencer.
    sds_sar u_sar (
        .clk(clk),
        .rst(rst),
        .start(sar_start),
        .comp_above(comp_sync_q),
        .trial_code(sar_trial),
        .busy(sar_busy),
        .done(sar_done),
        .result(sar_result)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pins_meta_q <= '0;
            pins_sync_q <= '0;
            comp_meta_q <= 1'b0;
            comp_sync_q <= 1'b0;
        end else begin
            pins_meta_q <= {system_supply_3v3, port_b_bus_power,
                port_a_bus_power};
            pins_sync_q <= pins_meta_q;
            comp_meta_q <= adc_comp_above;
            comp_sync_q <= comp_meta_q;
        end
    end

    assign supply_present = pins_sync_q[2];
    assign bus_present = pins_sync_q[1] | pins_sync_q[0];
    // Bus power without the 3.3 V system supply is a dead-battery boot.
    assign dead_now = bus_present & ~supply_present;
    assign start_elapsed = (start_cnt_q == '0);

    // Ratio bands, each limit scaled by 255. A result on the shared 0.1425
    // limit, LIM_CODE3, lands in code 3 because each band starts at its own limit.
    assign result_code =
        (sar_result >= sds_pkg::LIM_CODE7) ? 3'h7 :
        (sar_result >= sds_pkg::LIM_CODE6) ? 3'h6 :
        (sar_result >= sds_pkg::LIM_CODE5) ? 3'h5 :
        (sar_result >= sds_pkg::LIM_CODE4) ? 3'h4 :
        (sar_result >= sds_pkg::LIM_CODE3) ? 3'h3 :
        (sar_result >= sds_pkg::LIM_CODE2) ? 3'h2 :
        (sar_result >= sds_pkg::LIM_CODE1) ? 3'h1 :
        3'h0;

    // Start a conversion whenever the sequencer sits in a converting state
    // and the converter is idle and has not just finished.
    assign sar_start = !sar_busy && !sar_done &&
        ((state_q == sds_pkg::ST_CONV_ONE) ||
         (state_q == sds_pkg::ST_CONV_TWO) ||
         (state_q == sds_pkg::ST_FW_CONV));

    always_comb begin
        state_d = state_q;
        start_cnt_d = start_cnt_q;
        mux_d = mux_q;
        result_d = result_q;
        result_valid_d = result_valid_q;
        one_code_d = one_code_q;
        two_code_d = two_code_q;
        straps_valid_d = straps_valid_q;
        if (sar_done) begin
            result_d = sar_result;
            result_valid_d = 1'b1;
        end
        case (state_q)
            sds_pkg::ST_STARTUP: begin
                if (!start_elapsed) begin
                    start_cnt_d = start_cnt_q - 1'b1;
                end else begin
                    mux_d = sds_pkg::MUX_STRAP_ONE;
                    state_d = sds_pkg::ST_CONV_ONE;
                end
            end
            sds_pkg::ST_CONV_ONE: begin
                if (sar_done) begin
                    one_code_d = result_code;
                    mux_d = sds_pkg::MUX_STRAP_TWO;
                    state_d = sds_pkg::ST_CONV_TWO;
                end
            end
            sds_pkg::ST_CONV_TWO: begin
                if (sar_done) begin
                    two_code_d = result_code;
                    straps_valid_d = 1'b1;
                    state_d = sds_pkg::ST_READY;
                end
            end
            sds_pkg::ST_READY: begin
                // Later conversions never touch the latched strap codes.
                if (fw_conv_req) begin
                    mux_d = fw_mux_sel;
                    result_valid_d = 1'b0;
                    state_d = sds_pkg::ST_FW_CONV;
                end
            end
            sds_pkg::ST_FW_CONV: begin
                if (sar_done) begin
                    state_d = sds_pkg::ST_READY;
                end
            end
            default: begin
                state_d = sds_pkg::ST_STARTUP;
            end
        endcase
    end

    // The pull-down is on from reset so a source will power the bus, and it
    // stays off once released until the next power-on reset.
    always_comb begin
        pulldown_d = pulldown_q;
        if (fw_pulldown_release) begin
            pulldown_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= sds_pkg::ST_STARTUP;
            start_cnt_q <= sds_pkg::CNT_W'(sds_pkg::STARTUP_CYC);
            mux_q <= sds_pkg::MUX_STRAP_ONE;
            trial_q <= sds_pkg::RESULT_RST;
            result_q <= sds_pkg::RESULT_RST;
            result_valid_q <= 1'b0;
            fw_busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_cnt_q <= start_cnt_d;
            mux_q <= mux_d;
            trial_q <= sar_trial;
            result_q <= result_d;
            result_valid_q <= result_valid_d;
            fw_busy_q <= (state_d != sds_pkg::ST_READY);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            one_code_q <= sds_pkg::CODE_RST;
            two_code_q <= sds_pkg::CODE_RST;
            straps_valid_q <= 1'b0;
            pulldown_q <= 1'b1;
        end else begin
            one_code_q <= one_code_d;
            two_code_q <= two_code_d;
            straps_valid_q <= straps_valid_d;
            pulldown_q <= pulldown_d;
        end
    end

    // Start-up selections follow the latched codes only once both are known,
    // so no half-decoded setting ever reaches the outputs.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dead_q <= 1'b0;
            addr_sel_q <= sds_pkg::CODE_RST;
            sink_path_q <= 1'b0;
            cfg_sel_q <= sds_pkg::CODE_RST;
        end else begin
            dead_q <= dead_now;
            if (straps_valid_q) begin
                addr_sel_q <= one_code_q;
                cfg_sel_q <= two_code_q;
                sink_path_q <= dead_now &&
                    (two_code_q != sds_pkg::CODE_SAFE);
            end
        end
    end

    assign adc_trial_code = trial_q;
    assign adc_mux_sel = mux_q;
    assign adc_result = result_q;
    assign adc_result_valid = result_valid_q;
    assign fw_conv_busy = fw_busy_q;
    assign strap_one_code = one_code_q;
    assign strap_two_code = two_code_q;
    assign straps_valid = straps_valid_q;
    assign dead_battery = dead_q;
    assign host_serial_port_addr_sel = addr_sel_q;
    assign sink_path_enable = sink_path_q;
    assign default_config_sel = cfg_sel_q;
    assign sink_pulldown_enable = pulldown_q;
endmodule // sds_strap_decode

// ==== shared/sds_pkg.sv ====
// Constants shared by the strap decoder and its converter sequencer.
package sds_pkg;
    // Converter geometry.
    localparam int ADC_W = 8;
    localparam int BIT_IDX_W = 3;
    localparam int CODE_W = 3;
    localparam int MUX_W = 3;

    // Core clock and timing.
    localparam int CLK_PERIOD_PS = 8000;
    localparam int SETTLE_NS = 40;
    localparam int SETTLE_CYC_RAW = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
    localparam int STARTUP_NS = 1000;
    localparam int STARTUP_CYC_RAW = (STARTUP_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int STARTUP_CYC = (STARTUP_CYC_RAW < 1) ? 1 : STARTUP_CYC_RAW;
    localparam int CNT_W = 8;

    // Converter input multiplexer selections.
    localparam logic [2:0] MUX_STRAP_ONE = 3'h0;
    localparam logic [2:0] MUX_STRAP_TWO = 3'h1;

    // Lowest 8-bit result of each code: ratio limit times 255, rounded up.
    localparam logic [7:0] LIM_CODE1 = 8'h06;
    localparam logic [7:0] LIM_CODE2 = 8'h13;
    localparam logic [7:0] LIM_CODE3 = 8'h25;
    localparam logic [7:0] LIM_CODE4 = 8'h3D;
    localparam logic [7:0] LIM_CODE5 = 8'h5E;
    localparam logic [7:0] LIM_CODE6 = 8'hB5;
    localparam logic [7:0] LIM_CODE7 = 8'hE8;

    // Strap code that keeps the sink path shut in a dead-battery boot.
    localparam logic [2:0] CODE_SAFE = 3'h0;

    // Reset values.
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [2:0] CODE_RST = 3'h0;

    typedef enum logic [2:0] {
        ST_STARTUP,
        ST_CONV_ONE,
        ST_CONV_TWO,
        ST_READY,
        ST_FW_CONV
    } sds_state_type;
endpackage

// ==== rtl/sds_sar.sv ====
// Successive-approximation sequencer for the 8-bit converter.
`timescale 1ns/10ps
module sds_sar (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic comp_above,
    // Results
    output logic [sds_pkg::ADC_W-1:0] trial_code,
    output logic busy,
    output logic done,
    output logic [sds_pkg::ADC_W-1:0] result
);
    logic [sds_pkg::ADC_W-1:0] trial_q, trial_d;
    logic [sds_pkg::BIT_IDX_W-1:0] bit_q, bit_d;
    logic [sds_pkg::CNT_W-1:0] wait_q, wait_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [sds_pkg::ADC_W-1:0] result_q, result_d;
    logic [sds_pkg::ADC_W-1:0] bit_mask;
    logic settled;

    assign bit_mask = sds_pkg::ADC_W'(1) << bit_q;
    assign settled = (wait_q == '0);

    // The comparator is read only after the settle count, which covers both
    // the analog settling and the two-stage input synchroniser.
    always_comb begin
        trial_d = trial_q;
        bit_d = bit_q;
        wait_d = wait_q;
        busy_d = busy_q;
        done_d = 1'b0;
        result_d = result_q;
        if (!busy_q && start) begin
            busy_d = 1'b1;
            bit_d = sds_pkg::BIT_IDX_W'(sds_pkg::ADC_W - 1);
            trial_d = {1'b1, {(sds_pkg::ADC_W-1){1'b0}}};
            wait_d = sds_pkg::CNT_W'(sds_pkg::SETTLE_CYC);
        end else if (busy_q && !settled) begin
            wait_d = wait_q - 1'b1;
        end else if (busy_q) begin
            if (!comp_above) begin
                trial_d = trial_q & ~bit_mask;
            end
            if (bit_q == '0) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                result_d = comp_above ? trial_q : (trial_q & ~bit_mask);
            end else begin
                bit_d = bit_q - 1'b1;
                trial_d = (comp_above ? trial_q : (trial_q & ~bit_mask))
                    | (bit_mask >> 1);
                wait_d = sds_pkg::CNT_W'(sds_pkg::SETTLE_CYC);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trial_q <= sds_pkg::RESULT_RST;
            bit_q <= '0;
            wait_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            result_q <= sds_pkg::RESULT_RST;
        end else begin
            trial_q <= trial_d;
            bit_q <= bit_d;
            wait_q <= wait_d;
            busy_q <= busy_d;
            done_q <= done_d;
            result_q <= result_d;
        end
    end

    assign trial_code = trial_q;
    assign busy = busy_q;
    assign done = done_q;
    assign result = result_q;
endmodule // sds_sar

// ==== sim/sds_strap_decode_monitor.sv ====
// Port-level assertions for the strap decoder.
`timescale 1ns/10ps
module sds_strap_decode_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire logic system_supply_3v3,
    input wire logic port_a_bus_power,
    input wire logic fw_conv_req,
    input wire logic fw_pulldown_release,
    // Outputs
    input wire logic [7:0] adc_result,
    input wire logic adc_result_valid,
    input wire logic fw_conv_busy,
    input wire logic [2:0] strap_one_code,
    input wire logic [2:0] strap_two_code,
    input wire logic straps_valid,
    input wire logic dead_battery,
    input wire logic [2:0] host_serial_port_addr_sel,
    input wire logic sink_path_enable,
    input wire logic [2:0] default_config_sel,
    input wire logic sink_pulldown_enable
);
    function automatic logic [2:0] map_code(input logic [7:0] r);
        return (r >= sds_pkg::LIM_CODE7) ? 3'h7 :
            (r >= sds_pkg::LIM_CODE6) ? 3'h6 :
            (r >= sds_pkg::LIM_CODE5) ? 3'h5 :
            (r >= sds_pkg::LIM_CODE4) ? 3'h4 :
            (r >= sds_pkg::LIM_CODE3) ? 3'h3 :
            (r >= sds_pkg::LIM_CODE2) ? 3'h2 :
            (r >= sds_pkg::LIM_CODE1) ? 3'h1 : 3'h0;
    endfunction

    default clocking mcb @(posedge clk); endclocking
    default disable iff (rst);

    pd_release_a: assert property (
        fw_pulldown_release |=> !sink_pulldown_enable)
        else $error("pull-down kept after release");
    pd_cause_a: assert property (
        $fell(sink_pulldown_enable) |-> $past(fw_pulldown_release))
        else $error("pull-down dropped without release");
    addr_sel_a: assert property (
        straps_valid && $past(straps_valid)
        |-> host_serial_port_addr_sel == strap_one_code)
        else $error("address selection wrong");
    cfg_sel_a: assert property (
        straps_valid && $past(straps_valid)
        |-> default_config_sel == strap_two_code)
        else $error("config selection wrong");
    sink_safe_a: assert property (
        sink_path_enable
        |-> straps_valid && strap_two_code != sds_pkg::CODE_SAFE)
        else $error("sink path open without strap");
    codes_hold_a: assert property (straps_valid |=> straps_valid &&
        $stable(strap_one_code) && $stable(strap_two_code))
        else $error("strap codes changed");
    code_map_a: assert property (
        $rose(straps_valid) |-> strap_two_code == map_code(adc_result))
        else $error("strap code does not match result");
    fw_accept_a: assert property (
        fw_conv_req && straps_valid && !fw_conv_busy
        |-> ##[1:2] (fw_conv_busy && !adc_result_valid))
        else $error("conversion request not taken");
    dead_on_a: assert property (
        (!system_supply_3v3 && port_a_bus_power) [*5] |-> dead_battery)
        else $error("dead battery not flagged");
    dead_off_a: assert property (
        system_supply_3v3 [*5] |-> !dead_battery)
        else $error("dead battery flagged with supply");
endmodule // sds_strap_decode_monitor

bind sds_strap_decode sds_strap_decode_monitor sds_strap_decode_monitor_inst (
    .clk, .rst, .system_supply_3v3, .port_a_bus_power, .fw_conv_req,
    .fw_pulldown_release, .adc_result, .adc_result_valid, .fw_conv_busy,
    .strap_one_code, .strap_two_code, .straps_valid, .dead_battery,
    .host_serial_port_addr_sel, .sink_path_enable, .default_config_sel,
    .sink_pulldown_enable);

// ==== sim/sds_afe_model.sv ====
// Analog front end model: strap dividers, a firmware source, comparator.
`timescale 1ns/10ps
module sds_afe_model (
    // Clock
    input wire logic clk,
    // Converter side
    input wire logic [2:0] mux_sel,
    input wire logic [7:0] trial_code,
    output logic comp_above,
    // Source levels as fractions of the regulator, scaled by 255
    input wire logic [7:0] level_one,
    input wire logic [7:0] level_two,
    input wire logic [7:0] level_fw
);
    // Each strap level stands for a divider ratio set by the bench.
    wire logic [7:0] level_sel = (mux_sel == sds_pkg::MUX_STRAP_ONE) ?
        level_one : (mux_sel == sds_pkg::MUX_STRAP_TWO) ? level_two : level_fw;

    initial comp_above = 1'b0;
    always @(posedge clk) begin
        comp_above <= (level_sel >= trial_code);
    end
endmodule // sds_afe_model

// ==== sim/sds_strap_decode_tb.sv ====
// Self-checking bench for the power-up strap decoder.
`timescale 1ns/10ps
module sds_strap_decode_tb;
    logic clk, rst, system_supply_3v3, port_a_bus_power, port_b_bus_power;
    logic adc_comp_above, fw_conv_req, fw_pulldown_release, adc_result_valid;
    logic fw_conv_busy, straps_valid, dead_battery, sink_path_enable;
    logic sink_pulldown_enable;
    logic [7:0] adc_trial_code, adc_result, level_one, level_two, level_fw;
    logic [2:0] adc_mux_sel, fw_mux_sel, strap_one_code, strap_two_code;
    logic [2:0] host_serial_port_addr_sel, default_config_sel;
    logic [7:0] lv [18];
    logic [2:0] cd [18];
    int error_cnt = 0;
    int n_tests = 0;

    sds_strap_decode sds_strap_decode_inst (.clk, .rst, .system_supply_3v3,
        .port_a_bus_power, .port_b_bus_power, .adc_comp_above,
        .adc_trial_code, .adc_mux_sel, .fw_conv_req, .fw_mux_sel,
        .fw_pulldown_release, .adc_result, .adc_result_valid, .fw_conv_busy,
        .strap_one_code, .strap_two_code, .straps_valid, .dead_battery,
        .host_serial_port_addr_sel, .sink_path_enable, .default_config_sel,
        .sink_pulldown_enable);
    sds_afe_model sds_afe_model_inst (.clk, .mux_sel(adc_mux_sel),
        .trial_code(adc_trial_code), .comp_above(adc_comp_above),
        .level_one, .level_two, .level_fw);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Power-on with both straps and bus power set, then wait for the codes.
    task automatic strap_case(input int k);
        @(posedge clk);
        rst <= 1'b1;
        level_one <= lv[2*k];
        level_two <= lv[2*k+1];
        port_a_bus_power <= k[0];
        port_b_bus_power <= ~k[0];
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 1000 && straps_valid !== 1'b1; i++) @(negedge clk);
        repeat (6) @(negedge clk);
        check(8'(straps_valid), 8'h01);
        check(8'(strap_one_code), 8'(cd[2*k]));
        check(8'(strap_two_code), 8'(cd[2*k+1]));
        check(adc_result, lv[2*k+1]);
        check(adc_trial_code, lv[2*k+1]);
        check(8'(adc_mux_sel), 8'(sds_pkg::MUX_STRAP_TWO));
        check(8'(host_serial_port_addr_sel), 8'(cd[2*k]));
        check(8'(default_config_sel), 8'(cd[2*k+1]));
        check(8'(dead_battery), 8'h01);
        check(8'(sink_path_enable), 8'(cd[2*k+1] != 3'h0));
        check(8'(sink_pulldown_enable), 8'h01);
    endtask

    task automatic supply_case();
        @(posedge clk);
        system_supply_3v3 <= 1'b1;
        repeat (6) @(negedge clk);
        check(8'(dead_battery), 8'h00);
        check(8'(sink_path_enable), 8'h00);
        @(posedge clk);
        system_supply_3v3 <= 1'b0;
        repeat (6) @(negedge clk);
        check(8'(dead_battery), 8'h01);
        check(8'(sink_path_enable), 8'h01);
    endtask

    task automatic fw_conv(input logic [2:0] sel);
        @(posedge clk);
        fw_mux_sel <= sel;
        fw_conv_req <= 1'b1;
        @(posedge clk);
        fw_conv_req <= 1'b0;
        repeat (3) @(negedge clk);
        for (int i = 0; i < 300 && fw_conv_busy !== 1'b0; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        check(8'(fw_conv_busy), 8'h00);
        check(8'(adc_result_valid), 8'h01);
    endtask

    // Strap one's level moves after the latch; the codes must not follow.
    task automatic fw_case();
        @(posedge clk);
        level_fw <= 8'hA5;
        level_one <= 8'h40;
        fw_conv(3'h2);
        check(adc_result, 8'hA5);
        check(8'(adc_mux_sel), 8'h02);
        fw_conv(sds_pkg::MUX_STRAP_ONE);
        check(adc_result, 8'h40);
        check(8'(strap_one_code), 8'h00);
        check(8'(strap_two_code), 8'h07);
    endtask

    task automatic release_case();
        check(8'(sink_pulldown_enable), 8'h01);
        @(posedge clk);
        fw_pulldown_release <= 1'b1;
        @(posedge clk);
        fw_pulldown_release <= 1'b0;
        repeat (3) @(negedge clk);
        check(8'(sink_pulldown_enable), 8'h00);
        repeat (5) @(negedge clk);
        check(8'(sink_pulldown_enable), 8'h00);
    endtask

    initial begin
        rst = 1'b1;
        system_supply_3v3 = 1'b0;
        port_a_bus_power = 1'b1;
        port_b_bus_power = 1'b0;
        fw_conv_req = 1'b0;
        fw_mux_sel = 3'h0;
        fw_pulldown_release = 1'b0;
        level_one = 8'h00;
        level_two = 8'h00;
        level_fw = 8'h00;
        // Results on each side of every band edge, then the two extremes,
        // then a pair centred in its bands with the safe sink code on two.
        lv = '{8'h05, 8'h06, 8'h12, 8'h13, 8'h24, 8'h25, 8'h3C, 8'h3D,
            8'h5D, 8'h5E, 8'hB4, 8'hB5, 8'hE7, 8'hE8, 8'h00, 8'hFF,
            8'h89, 8'h03};
        cd = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4,
            3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h7, 3'h0, 3'h7,
            3'h5, 3'h0};
        // The centred pair runs first so the last power-up keeps code 7.
        strap_case(8);
        for (int k = 0; k < 8; k++) strap_case(k);
        supply_case();
        fw_case();
        release_case();
        give_verdict();
    end

    // Nine power-ups of under a thousand cycles each fit well inside this.
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule // sds_strap_decode_tb
